// [common/wdog_irq_regs.vh]
// Purpose: Offsets, field positions, reset values and timing counts for the watchdog block.
// Assumes: Word registers on a simple processor register port, byte offsets from the base.
// Notes: Only definitions live here.
`ifndef WDOG_IRQ_REGS_VH
`define WDOG_IRQ_REGS_VH
`define BLOCK_BASE_ADDR 32'h8000_3000
`define OFS_WDOG_CONTROL 8'h10
`define OFS_WDOG_SERVICE 8'h14
`define OFS_EVENT_STATUS 8'h18
`define OFS_EVENT_MASKS 8'h1C
// Control register fields.
`define CTL_ENABLE_BIT 0
`define CTL_ACTION_BIT 1
`define CTL_LOCK_BIT 2
`define CTL_PERIOD_LSB 8
`define CTL_PERIOD_MSB 14
`define CTL_COUNT_LSB 16
`define CTL_COUNT_MSB 22
// Action select reset value: interrupt.
`define CTL_ACTION_RESET 1'b1
// Status register fields.
`define ST_HIB_BIT 0
`define ST_DOZE_BIT 1
`define ST_RTC_BIT 2
`define ST_CAL_BIT 3
`define ST_WDOG_BIT 4
`define ST_PIN_LSB 8
`define ST_PIN_MSB 11
// Mask register fields.
`define MSK_TIMER_BIT 0
`define MSK_RTC_BIT 1
`define MSK_CAL_BIT 2
`define MSK_PIN_LSB 8
`define MSK_PIN_MSB 11
// Service key.
`define WDOG_KEY 32'hC0DE_5AFE
// One count step in microseconds at the nominal reference rate, and that rate in kHz.
`define WDOG_STEP_US 87000
`define REF_CLK_KHZ 24000
`define WDOG_STEP_REF_CYCLES (`WDOG_STEP_US * `REF_CLK_KHZ / 1000)
`endif

// [logic/wdog_irq_block.v]
// Purpose: Watchdog timer with key service plus the block's wake and event interrupt gathering.
// Assumes: clk is the reference oscillator; the core clock tick is ref / (prescale + 1).
// Notes: Registers are reached on a simple word register port with write and read strobes.
//        Wake pins pass a three-stage synchroniser before any pin event is reported.
//
// Functional notes
// - Watchdog disabled after reset until enabled.
// - Period programmable in 128 steps.
// - Seven-bit period and count, 0.087 s step.
// - Count field reads the present count.
// - Debug halt inhibits the watchdog completely.
// - Action select: one interrupt, zero reset.
// - Reset action triggers full power-on sequence.
// - Count held during retained sleep, then resumes.
// - Lock bit freezes control until system reset.
// - Only the exact key restarts the count.
// - Correct key clears pending watchdog interrupt.
// - Expiry sets flag; write one clears.
// - Interrupt output ORs all enabled sources.
// - Wake timer sets hibernate or doze flag.
// - RTC timeout sets flag, masked, write-one clear.
// - Four pins, each level or edge detect.
// - Pin events gated by their four masks.
// - Pin events work in sleep and run.
// - Calibration done sets flag, masked, cleared.
// - Non-retained wake resets control, count, flags and masks.
// - No counting in any sleep mode.
// - Control 0x10, service 0x14, status 0x18.
// - Tick paced by reference divided by prescale+1.
`timescale 1ns/1ps
`include "wdog_irq_regs.vh"

module wdog_irq_block #(
   parameter [31:0] STEP_REF_CYCLES = `WDOG_STEP_REF_CYCLES
) (
   input wire clk,
   input wire arst_n,
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [31:0] reg_wdata,
   output reg [31:0] reg_rdata,
   input wire [5:0] xtal_clkdiv,
   input wire debug_halt,
   input wire sleep_active,
   input wire wake_no_retention,
   input wire lowpower_is_doze,
   input wire wake_timer_fire,
   input wire rtc_timeout,
   input wire calib_done,
   input wire [3:0] keypad_wake_pins,
   input wire [3:0] pin_edge_mode,
   input wire [3:0] pin_active_level,
   output wire block_irq_out,
   output reg por_request
);

   // Block soft reset: a wake without core retention clears control, count, flags and masks like a reset.
   // The clear is synchronous and level sensitive; the pin synchronisers keep running
   // through it, but a wake edge whose event is detected while the clear is still high is lost, since the flag clear wins.
   wire clr = wake_no_retention;

   // Register decode; addresses are byte offsets from the block base, matched exactly.
   wire wr_ctl = reg_wr && (reg_addr == `OFS_WDOG_CONTROL);
   wire wr_svc = reg_wr && (reg_addr == `OFS_WDOG_SERVICE);
   wire wr_sts = reg_wr && (reg_addr == `OFS_EVENT_STATUS);
   wire wr_msk = reg_wr && (reg_addr == `OFS_EVENT_MASKS);
   wire key_ok = wr_svc && (reg_wdata == `WDOG_KEY);

   reg wdog_enable_bit_q;
   reg expiry_action_select_q;
   reg wdog_lock_bit_q;
   reg [6:0] wdog_period_field_q;
   reg [6:0] wdog_count_field_q;
   reg [5:0] div_cnt_q;
   reg [31:0] step_cnt_q;
   reg hib_q, doze_q, rtc_q, cal_q, wexp_q;
   reg [3:0] pin_q;
   reg timer_mask_q, rtc_mask_q, cal_mask_q;
   reg [3:0] pin_mask_q;
   reg [3:0] pin_s1_q, pin_s2_q, pin_s3_q;
   reg [3:0] pin_acc_q;
   reg [3:0] pin_fill_q;

   // Core tick enable: one pulse every xtal_clkdiv+1 reference cycles.
   // The compare is >= so that lowering the prescale while the divider sits above the new
   // value gives a tick at once instead of a wrap through all 64 states.
   wire core_tick = (div_cnt_q >= xtal_clkdiv);
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_cnt_q <= 6'h00;
      end else if (core_tick) begin
         div_cnt_q <= 6'h00;
      end else begin
         div_cnt_q <= div_cnt_q + 6'h01;
      end
   end

   // The count may advance only when enabled, awake and not under debug halt.
   // Sleep of either kind freezes it without loss, so it resumes where it stopped.
   wire run = wdog_enable_bit_q && !sleep_active && !debug_halt;
   wire step_done = run && core_tick && (step_cnt_q >= STEP_REF_CYCLES - 32'd1);
   // Expiry is declared as the count lands on the period; flag set only while armed.
   // A period of zero acts like one, and a period lowered below the present count
   // expires at the next step rather than waiting for the count to wrap.
   wire expire = step_done && ((wdog_count_field_q + 7'h01) >= wdog_period_field_q);

   // Control register; the lock stays until a reset clears it.
   // While locked the whole word is ignored, enable included, so run-away code cannot
   // switch the watchdog off; the count field is read-only and never written here.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wdog_enable_bit_q <= 1'b0;
         expiry_action_select_q <= `CTL_ACTION_RESET;
         wdog_lock_bit_q <= 1'b0;
         wdog_period_field_q <= 7'h00;
      end else if (clr) begin
         wdog_enable_bit_q <= 1'b0;
         expiry_action_select_q <= `CTL_ACTION_RESET;
         wdog_lock_bit_q <= 1'b0;
         wdog_period_field_q <= 7'h00;
      end else if (wr_ctl && !wdog_lock_bit_q) begin
         wdog_enable_bit_q <= reg_wdata[`CTL_ENABLE_BIT];
         expiry_action_select_q <= reg_wdata[`CTL_ACTION_BIT];
         wdog_lock_bit_q <= reg_wdata[`CTL_LOCK_BIT];
         wdog_period_field_q <= reg_wdata[`CTL_PERIOD_MSB:`CTL_PERIOD_LSB];
      end
   end

   // Step prescaler and the seven-bit count; a key write restarts both from zero.
   // The step counter runs on core ticks only, so the prescale stretches every step alike.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         step_cnt_q <= 32'h0000_0000;
         wdog_count_field_q <= 7'h00;
      end else if (clr || key_ok || !wdog_enable_bit_q) begin
         step_cnt_q <= 32'h0000_0000;
         wdog_count_field_q <= 7'h00;
      end else if (step_done) begin
         step_cnt_q <= 32'h0000_0000;
         // After expiry the count starts over, so an ignored interrupt repeats.
         wdog_count_field_q <= expire ? 7'h00 : wdog_count_field_q + 7'h01;
      end else if (run && core_tick) begin
         step_cnt_q <= step_cnt_q + 32'd1;
      end
   end

   // Power-on reset request pulse when reset is the chosen response.
   // Registered so the reset sequencer sees a clean one-cycle pulse; a block clear in
   // the same cycle wins, since the clear means the device is already restarting.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         por_request <= 1'b0;
      end else begin
         por_request <= expire && !expiry_action_select_q && !clr;
      end
   end

   // Pin synchronisers: three stages; a new pin level counts only once stages two and
   // three agree, so one unsettled sample can never be taken as a change.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_s1_q <= 4'h0;
         pin_s2_q <= 4'h0;
         pin_s3_q <= 4'h0;
      end else begin
         pin_s1_q <= keypad_wake_pins;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   // Fill marker: a one walks through four stages after reset. Until it arrives the
   // accepted levels are loaded from real samples but no event is reported, so a pin
   // that idles high does not look like an edge straight out of reset.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_fill_q <= 4'h0;
      end else begin
         pin_fill_q <= {pin_fill_q[2:0], 1'b1};
      end
   end
   wire pin_primed = pin_fill_q[3];

   // Accepted level per pin: follows stage three only while stages two and three agree.
   wire [3:0] pin_settled = ~(pin_s2_q ^ pin_s3_q);
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_acc_q <= 4'h0;
      end else begin
         pin_acc_q <= (pin_s3_q & pin_settled) | (pin_acc_q & ~pin_settled);
      end
   end

   // Per-pin detect: edge mode flags a settled change, level mode flags the chosen level.
   // No clock gating here, so the detect works in sleep and in run alike.
   wire [3:0] pin_evt;
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : pin_det
         assign pin_evt[g] = pin_primed && (pin_edge_mode[g] ?
                             (pin_settled[g] && (pin_s3_q[g] != pin_acc_q[g])) :
                             (pin_acc_q[g] == pin_active_level[g]));
      end
   endgenerate

   // Sticky event flags: set wins over a write-one clear in the same cycle.
   // An event that lands with the clearing write is kept, so no wake cause is lost.
   wire [31:0] w1c = wr_sts ? reg_wdata : 32'h0000_0000;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hib_q <= 1'b0;
         doze_q <= 1'b0;
         rtc_q <= 1'b0;
         cal_q <= 1'b0;
         wexp_q <= 1'b0;
         pin_q <= 4'h0;
      end else if (clr) begin
         hib_q <= 1'b0;
         doze_q <= 1'b0;
         rtc_q <= 1'b0;
         cal_q <= 1'b0;
         wexp_q <= 1'b0;
         pin_q <= 4'h0;
      end else begin
         hib_q <= (wake_timer_fire && !lowpower_is_doze) ||
                  (hib_q && !w1c[`ST_HIB_BIT]);
         doze_q <= (wake_timer_fire && lowpower_is_doze) ||
                   (doze_q && !w1c[`ST_DOZE_BIT]);
         rtc_q <= rtc_timeout || (rtc_q && !w1c[`ST_RTC_BIT]);
         cal_q <= calib_done || (cal_q && !w1c[`ST_CAL_BIT]);
         wexp_q <= expire || (wexp_q && !w1c[`ST_WDOG_BIT] &&
                   !(key_ok && expiry_action_select_q));
         pin_q <= pin_evt | (pin_q & ~w1c[`ST_PIN_MSB:`ST_PIN_LSB]);
      end
   end

   // Interrupt masks.
   // Masking a source only hides its request; the flag itself stays set until cleared.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         timer_mask_q <= 1'b0;
         rtc_mask_q <= 1'b0;
         cal_mask_q <= 1'b0;
         pin_mask_q <= 4'h0;
      end else if (clr) begin
         timer_mask_q <= 1'b0;
         rtc_mask_q <= 1'b0;
         cal_mask_q <= 1'b0;
         pin_mask_q <= 4'h0;
      end else if (wr_msk) begin
         timer_mask_q <= reg_wdata[`MSK_TIMER_BIT];
         rtc_mask_q <= reg_wdata[`MSK_RTC_BIT];
         cal_mask_q <= reg_wdata[`MSK_CAL_BIT];
         pin_mask_q <= reg_wdata[`MSK_PIN_MSB:`MSK_PIN_LSB];
      end
   end

   // One request line: the OR of every masked source; the action select masks the watchdog.
   // Kept combinational so the request drops in the very cycle that a clearing write
   // or a mask change takes effect, with no stale extra cycle at the controller.
   assign block_irq_out = (timer_mask_q && (hib_q || doze_q)) ||
                          (rtc_mask_q && rtc_q) ||
                          (|(pin_mask_q & pin_q)) ||
                          (cal_mask_q && cal_q) ||
                          (expiry_action_select_q && wexp_q);

   // Read data registered one cycle after the read strobe; unmapped reads return zero.
   // Only the addressed fields are loaded, so reserved bits always read as zero.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         reg_rdata <= 32'h0000_0000;
         case (reg_addr)
            `OFS_WDOG_CONTROL: begin
               reg_rdata[`CTL_ENABLE_BIT] <= wdog_enable_bit_q;
               reg_rdata[`CTL_ACTION_BIT] <= expiry_action_select_q;
               reg_rdata[`CTL_LOCK_BIT] <= wdog_lock_bit_q;
               reg_rdata[`CTL_PERIOD_MSB:`CTL_PERIOD_LSB] <= wdog_period_field_q;
               reg_rdata[`CTL_COUNT_MSB:`CTL_COUNT_LSB] <= wdog_count_field_q;
            end
            `OFS_EVENT_STATUS: begin
               reg_rdata[`ST_HIB_BIT] <= hib_q;
               reg_rdata[`ST_DOZE_BIT] <= doze_q;
               reg_rdata[`ST_RTC_BIT] <= rtc_q;
               reg_rdata[`ST_CAL_BIT] <= cal_q;
               reg_rdata[`ST_WDOG_BIT] <= wexp_q;
               reg_rdata[`ST_PIN_MSB:`ST_PIN_LSB] <= pin_q;
            end
            `OFS_EVENT_MASKS: begin
               reg_rdata[`MSK_TIMER_BIT] <= timer_mask_q;
               reg_rdata[`MSK_RTC_BIT] <= rtc_mask_q;
               reg_rdata[`MSK_CAL_BIT] <= cal_mask_q;
               reg_rdata[`MSK_PIN_MSB:`MSK_PIN_LSB] <= pin_mask_q;
            end
            default: begin
               reg_rdata <= 32'h0000_0000;
            end
         endcase
      end
   end

endmodule // wdog_irq_block

// [sim/wdog_host_bus.sv]
// Purpose: Processor-side register master for the watchdog block.
// Assumes: Requests are taken on the rising edge that sees the strobe.
// Notes: Released write data is inverted so stale words never look current.
`timescale 1ns/1ps
module wdog_host_bus(
   input wire clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [31:0] reg_wdata,
   input wire [31:0] reg_rdata
);
   // Idle bus from time zero.
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 32'h0000_0000;
   end
   // One whole word per write, held up to its taking edge.
   task wr(input [7:0] a, input [31:0] v);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      reg_wdata = ~v;
   endtask
   // Read data is registered, so it is taken just after the taking edge.
   task rd(input [7:0] a, output [31:0] v);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      v = reg_rdata;
   endtask
endmodule // wdog_host_bus

// [sim/wdog_irq_block_assertions.sv]
// Purpose: Port checks of the watchdog block.
// Assumes: One clock; checks sleep while arst_n is low.
// Notes: Silent unless a check fails.
`timescale 1ns/1ps
module wdog_irq_checks(
   input wire clk,
   input wire arst_n,
   input wire [7:0] reg_addr,
   input wire reg_rd,
   input wire reg_wr,
   input wire [31:0] reg_wdata,
   input wire [31:0] reg_rdata,
   input wire debug_halt,
   input wire sleep_active,
   input wire wake_no_retention,
   input wire block_irq_out,
   input wire por_request
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Bus steps shared by the multi-step checks.
   sequence s_key; reg_wr && reg_addr == 8'h14 && reg_wdata == 32'hC0DE_5AFE; endsequence
   sequence s_ctl_rd; reg_rd && reg_addr == 8'h10; endsequence
   property p_por_pulse; por_request |=> !por_request; endproperty
   a_por_pulse: assert property (p_por_pulse) else $error("reset request too long");
   property p_unmapped; reg_rd && reg_addr == 8'h20 |=> reg_rdata == 32'h0000_0000; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_quiet; $rose(arst_n) |-> (!por_request && !block_irq_out) [*3]; endproperty
   a_quiet: assert property (p_quiet) else $error("activity right after reset");
   property p_halt; debug_halt [*3] |-> !por_request; endproperty
   a_halt: assert property (p_halt) else $error("expiry during halt");
   property p_sleep; sleep_active [*3] |-> !por_request; endproperty
   a_sleep: assert property (p_sleep) else $error("expiry during sleep");
   property p_clear; wake_no_retention [*2] |-> !block_irq_out && !por_request; endproperty
   a_clear: assert property (p_clear) else $error("outputs live after clear");
   property p_key; s_key ##2 s_ctl_rd |=> reg_rdata[22:16] == 7'h00; endproperty
   a_key: assert property (p_key) else $error("count not restarted");
   property p_clr_ctl;
      $fell(wake_no_retention) ##1 s_ctl_rd |=> reg_rdata == 32'h0000_0002;
   endproperty
   a_clr_ctl: assert property (p_clr_ctl) else $error("control not at reset value");
endmodule // wdog_irq_checks
bind wdog_irq_block wdog_irq_checks chk_u(.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
   .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .debug_halt(debug_halt), .sleep_active(sleep_active), .wake_no_retention(wake_no_retention),
   .block_irq_out(block_irq_out), .por_request(por_request));

// [sim/tb_wdog_irq_block.sv]
// Purpose: Self-checking bench of the watchdog block.
// Assumes: Step shortened to 4 ticks so expiries come fast.
// Notes: Pins run in edge mode, apart from one short level-mode check on pin 0.
`timescale 1ns/1ps
module tb_wdog_irq_block;
   logic clk, arst_n, debug_halt, sleep_active, wake_no_retention, lowpower_is_doze;
   logic wake_timer_fire, rtc_timeout, calib_done, reg_wr, reg_rd;
   logic [5:0] xtal_clkdiv;
   logic [3:0] keypad_wake_pins, pin_edge_mode, pin_active_level;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   wire block_irq_out, por_request;
   integer errors = 0, n_tests = 0, seed = 32'ha963, k, n;
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   wdog_irq_block #(.STEP_REF_CYCLES(32'h0000_0004)) dut_u(.clk(clk), .arst_n(arst_n),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .xtal_clkdiv(xtal_clkdiv), .debug_halt(debug_halt),
      .sleep_active(sleep_active), .wake_no_retention(wake_no_retention),
      .lowpower_is_doze(lowpower_is_doze), .wake_timer_fire(wake_timer_fire),
      .rtc_timeout(rtc_timeout), .calib_done(calib_done), .keypad_wake_pins(keypad_wake_pins),
      .pin_edge_mode(pin_edge_mode), .pin_active_level(pin_active_level),
      .block_irq_out(block_irq_out), .por_request(por_request));
   wdog_host_bus bus_u(.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   task chk(input [31:0] got, input [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task give_verdict;
      $display("errors %0d, checks %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Waits whole cycles and steps past the edge so updates have landed.
   task tick(input integer c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   // Source k: 0 hibernate, 1 doze, 2 rtc, 3 calibration, 4..7 pins.
   function [31:0] st_exp(input integer k);
      st_exp = 32'h0000_0001 << (k < 4 ? k : k + 4);
   endfunction
   function [31:0] mk_exp(input integer k);
      mk_exp = 32'h0000_0001 << (k < 2 ? 0 : k < 4 ? k - 1 : k + 4);
   endfunction
   task fire(input integer k);
      tick(1);
      lowpower_is_doze = (k == 1);
      wake_timer_fire = (k < 2);
      rtc_timeout = (k == 2);
      calib_done = (k == 3);
      if (k > 3) keypad_wake_pins[k-4] = ~keypad_wake_pins[k-4];
      tick(1);
      {wake_timer_fire, rtc_timeout, calib_done} = 3'b000;
      tick(6);
   endtask
   // Hang guard, well beyond the expected run.
   initial begin
      #150000;
      errors++;
      give_verdict;
   end
   initial begin
      {arst_n, debug_halt, sleep_active, wake_no_retention, lowpower_is_doze} = 5'b00000;
      {wake_timer_fire, rtc_timeout, calib_done} = 3'b000;
      xtal_clkdiv = 6'h00;
      keypad_wake_pins = $random(seed);
      pin_active_level = $random(seed);
      pin_edge_mode = 4'hF;
      tick(12);
      arst_n = 1'b1;
      bus_u.rd(8'h10, d);
      chk(d, 32'h0000_0002);
      bus_u.rd(8'h20, d);
      chk(d, 32'h0000_0000);
      for (k = 0; k < 8; k++) begin
         fire(k);
         bus_u.rd(8'h18, d);
         chk(d, st_exp(k));
         chk(block_irq_out, 0);
         bus_u.wr(8'h1C, mk_exp(k));
         chk(block_irq_out, 1);
         bus_u.wr(8'h18, st_exp(k));
         chk(block_irq_out, 0);
         bus_u.wr(8'h1C, 32'h0000_0000);
      end
      // Level mode on pin 0: the flag re-sets while the level holds, then clears.
      pin_edge_mode[0] = 1'b0;
      pin_active_level[0] = keypad_wake_pins[0];
      bus_u.wr(8'h18, 32'h0000_0100);
      bus_u.rd(8'h18, d);
      chk(d, 32'h0000_0100);
      pin_active_level[0] = ~keypad_wake_pins[0];
      bus_u.wr(8'h18, 32'h0000_0100);
      bus_u.rd(8'h18, d);
      chk(d, 32'h0000_0000);
      pin_edge_mode[0] = 1'b1;
      // Period 3 at one tick per cycle expires 12 cycles after enabling.
      bus_u.wr(8'h10, 32'h0000_0303);
      n = 1;
      while (block_irq_out !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      chk(n > 9 && n < 14, 1);
      bus_u.rd(8'h18, d);
      chk(d & 32'h0000_0010, 32'h0000_0010);
      bus_u.wr(8'h14, 32'hC0DE_5AFE ^ ($random(seed) | 1));
      chk(block_irq_out, 1);
      bus_u.wr(8'h14, 32'hC0DE_5AFE);
      chk(block_irq_out, 0);
      bus_u.rd(8'h10, d);
      chk(d, 32'h0000_0303);
      tick(1);
      bus_u.rd(8'h10, d);
      chk(d, 32'h0001_0303);
      debug_halt = 1'b1;
      tick(40);
      chk(block_irq_out, 0);
      debug_halt = 1'b0;
      sleep_active = 1'b1;
      tick(40);
      chk(block_irq_out, 0);
      sleep_active = 1'b0;
      bus_u.rd(8'h10, d);
      chk(d, 32'h0001_0303);
      bus_u.rd(8'h10, d);
      chk(d, 32'h0002_0303);
      bus_u.wr(8'h10, 32'h0000_0307);
      bus_u.wr(8'h10, 32'h0000_0000);
      bus_u.rd(8'h10, d);
      chk(d & 32'h0000_7F07, 32'h0000_0307);
      wake_no_retention = 1'b1;
      tick(2);
      wake_no_retention = 1'b0;
      bus_u.rd(8'h10, d);
      chk(d, 32'h0000_0002);
      xtal_clkdiv = {$random(seed)} % 4;
      bus_u.wr(8'h10, 32'h0000_0201);
      n = 1;
      while (por_request !== 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
      chk(n >= 7 * xtal_clkdiv + 8 && n <= 8 * xtal_clkdiv + 8, 1);
      chk(block_irq_out, 0);
      // Lock, then a mid-run reset must unlock and restore the control reset value.
      bus_u.wr(8'h10, 32'h0000_0004);
      arst_n = 1'b0;
      tick(2);
      arst_n = 1'b1;
      bus_u.rd(8'h10, d);
      chk(d, 32'h0000_0002);
      bus_u.wr(8'h10, 32'h0000_0202);
      bus_u.rd(8'h10, d);
      chk(d, 32'h0000_0202);
      debug_halt = 1'b1;
      tick(60);
      give_verdict;
   end
endmodule // tb_wdog_irq_block
